// ### rtl/srx_rx_config.sv
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "srx_defs.svh"

module srx_rx_config
   import srx_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // system
   input  wire logic              CLK,
   input  wire logic              SYS_RST,
   input  wire logic              CE,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // serial link, receive side
   input  wire logic              RX_SERIAL_CLOCK,
   input  wire logic              RX_FSYNC,
   input  wire logic              RX_DATA,
   // status
   output logic                   RX_WORD_VALID,
   output logic                   TX_EDGE_FALLING
);

   // the offset decode reads PADDR[7:0], so narrower buses are rejected
   if (ADDR_W < 8)
   begin : g_addr_w_check
      $error("ADDR_W must be at least 8");
   end

   function automatic logic [5:0] word_bits(input logic [2:0] code);
      case (code)
         3'h0:    word_bits = 6'd8;
         3'h1:    word_bits = 6'd12;
         3'h2:    word_bits = 6'd16;
         3'h3:    word_bits = 6'd20;
         3'h4:    word_bits = 6'd24;
         default: word_bits = 6'd32;
      endcase
   endfunction

   function automatic logic [15:0] mu_expand(input logic [7:0] x);
      logic [7:0]  u;
      logic [15:0] t;
      u = ~x;
      t = ({12'h000, u[3:0]} << 3) + 16'h0084;
      t = t << u[6:4];
      t = t - 16'h0084;
      mu_expand = u[7] ? 16'(-t) : t;
   endfunction

   function automatic logic [15:0] a_expand(input logic [7:0] x);
      logic [7:0]  a;
      logic [15:0] t;
      a = x ^ 8'h55;
      t = ({12'h000, a[3:0]} << 4) + 16'h0008;
      if (a[6:4] != 3'h0)
         t = (t + 16'h0100) << (a[6:4] - 3'h1);
      a_expand = a[7] ? t : 16'(-t);
   endfunction

   // register side
   logic [15:0] pin_control;
   logic [15:0] receive_control_one;
   logic [15:0] receive_control_two;
   logic [15:0] transmit_control_one;
   logic [31:0] rx_word;
   logic        rx_full;
   logic        rx_overrun;
   logic        tgl_s1;
   logic        tgl_s2;
   logic        tgl_s3;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tx_edge_falling;

   logic [15:0] next_pin_control;
   logic [15:0] next_receive_control_one;
   logic [15:0] next_receive_control_two;
   logic [15:0] next_transmit_control_one;
   logic [31:0] next_rx_word;
   logic        next_rx_full;
   logic        next_rx_overrun;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_tx_edge_falling;

   // link-side word handed across with a toggle
   logic [31:0] lk_hold;
   logic        lk_tgl;

   logic [7:0]  addr_lo;
   logic        addr_hit;
   logic        setup_ph;
   logic        access_ph;
   logic [31:0] rd_value;

   always_comb
   begin
      addr_lo   = PADDR[7:0];
      setup_ph  = PSEL && (!PENABLE || !pready);
      access_ph = PSEL && PENABLE && pready;
      addr_hit  = ((PADDR >> 8) == '0) && (addr_lo == `SRX_OFF_PIN || addr_lo == `SRX_OFF_RC1 ||
                  addr_lo == `SRX_OFF_RC2 || addr_lo == `SRX_OFF_TC1 || addr_lo == `SRX_OFF_DATA ||
                  addr_lo == `SRX_OFF_STAT);
      case (addr_lo)
         `SRX_OFF_PIN:  rd_value = {16'h0000, pin_control};
         `SRX_OFF_RC1:  rd_value = {16'h0000, receive_control_one};
         `SRX_OFF_RC2:  rd_value = {16'h0000, receive_control_two};
         `SRX_OFF_TC1:  rd_value = {16'h0000, transmit_control_one};
         `SRX_OFF_DATA: rd_value = rx_word;
         `SRX_OFF_STAT: rd_value = {30'h0, rx_overrun, rx_full};
         default:       rd_value = 32'h0000_0000;
      endcase
      if (!addr_hit)
         rd_value = 32'h0000_0000;

      next_pin_control          = pin_control;
      next_receive_control_one  = receive_control_one;
      next_receive_control_two  = receive_control_two;
      next_transmit_control_one = transmit_control_one;
      next_rx_word              = rx_word;
      next_rx_full              = rx_full;
      next_rx_overrun           = rx_overrun;
      next_prdata               = prdata;
      next_pready               = 1'b0;
      next_pslverr              = 1'b0;

      // answer registered in setup; a stall under CE low answers late
      if (setup_ph)
      begin
         next_pready  = 1'b1;
         next_pslverr = !addr_hit;
         next_prdata  = PWRITE ? 32'h0000_0000 : rd_value;
      end

      if (access_ph && PWRITE && addr_hit)
      begin
         case (addr_lo)
            `SRX_OFF_PIN: next_pin_control = PWDATA[15:0] & `SRX_PIN_MASK;
            `SRX_OFF_RC1: next_receive_control_one = PWDATA[15:0] & `SRX_CTL1_MASK;
            `SRX_OFF_RC2: next_receive_control_two = PWDATA[15:0] & `SRX_CTL2_MASK;
            `SRX_OFF_TC1: next_transmit_control_one = PWDATA[15:0] & `SRX_CTL1_MASK;
            default:      next_pin_control = pin_control;
         endcase
      end

      if (access_ph && !PWRITE && addr_lo == `SRX_OFF_DATA && addr_hit)
         next_rx_full = 1'b0;
      if (access_ph && !PWRITE && addr_lo == `SRX_OFF_STAT && addr_hit)
         next_rx_overrun = 1'b0;

      // arriving word placed after the clears so a set wins
      if (tgl_s2 != tgl_s3)
      begin
         next_rx_word = lk_hold;
         next_rx_full = 1'b1;
         if (rx_full)
            next_rx_overrun = 1'b1;
      end

      next_tx_edge_falling = pin_control[`SRX_TXPOL_BIT];
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         pin_control          <= `SRX_RST_VAL;
         receive_control_one  <= `SRX_RST_VAL;
         receive_control_two  <= `SRX_RST_VAL;
         transmit_control_one <= `SRX_RST_VAL;
         rx_word              <= 32'h0000_0000;
         rx_full              <= 1'b0;
         rx_overrun           <= 1'b0;
         tgl_s1               <= 1'b0;
         tgl_s2               <= 1'b0;
         tgl_s3               <= 1'b0;
         prdata               <= 32'h0000_0000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
         tx_edge_falling      <= 1'b0;
      end
      else if (CE)
      begin
         pin_control          <= next_pin_control;
         receive_control_one  <= next_receive_control_one;
         receive_control_two  <= next_receive_control_two;
         transmit_control_one <= next_transmit_control_one;
         rx_word              <= next_rx_word;
         rx_full              <= next_rx_full;
         rx_overrun           <= next_rx_overrun;
         tgl_s1               <= lk_tgl;
         tgl_s2               <= tgl_s1;
         tgl_s3               <= tgl_s2;
         prdata               <= next_prdata;
         pready               <= next_pready;
         pslverr              <= next_pslverr;
         tx_edge_falling      <= next_tx_edge_falling;
      end
   end

   assign PRDATA          = prdata;
   assign PREADY          = pready;
   assign PSLVERR         = pslverr;
   assign RX_WORD_VALID   = rx_full;
   assign TX_EDGE_FALLING = tx_edge_falling;

   // link side
   // polarity picks the sampling edge; change it only while the link is quiet
   logic lk_clk;
   assign lk_clk = pin_control[`SRX_RXPOL_BIT] ? RX_SERIAL_CLOCK : ~RX_SERIAL_CLOCK;

   // config is quasi-static: two-flop carry, stable before a frame starts
   logic        lk_rst_m, lk_rst, lk_ce_m, lk_ce;
   logic [31:0] lk_cfg_m, lk_cfg;
   srx_state_t  state, next_state;
   logic [1:0]  dcnt, next_dcnt;
   logic [5:0]  bit_cnt, next_bit_cnt;
   logic [6:0]  word_cnt, next_word_cnt;
   logic        phase_b, next_phase_b;
   logic [31:0] sh, next_sh;
   logic [31:0] next_lk_hold;
   logic        next_lk_tgl;

   logic [15:0] c1, c2;
   logic        eff_b, start, take, first, word_done, lsb_first;
   logic [2:0]  cur_wc;
   logic [6:0]  cur_len;
   logic [1:0]  dly;
   logic [31:0] src, shifted, result;
   logic [5:0]  bits;
   logic [15:0] lin;

   always_comb
   begin
      c1 = lk_cfg[15:0];
      c2 = lk_cfg[31:16];
      start = RX_FSYNC && (state == S_IDLE || !c2[`SRX_FIG_BIT]);
      eff_b = start ? 1'b0 : phase_b;
      cur_wc  = eff_b ? c2[`SRX_WL_HI:`SRX_WL_LO] : c1[`SRX_WL_HI:`SRX_WL_LO];
      cur_len = eff_b ? c2[`SRX_LEN_HI:`SRX_LEN_LO] : c1[`SRX_LEN_HI:`SRX_LEN_LO];
      dly     = c2[`SRX_DLY_HI:`SRX_DLY_LO];
      lsb_first = (srx_cmp_t'(c2[`SRX_CMP_HI:`SRX_CMP_LO]) == CMP_LSB) && (cur_wc == 3'h0);

      next_state    = state;
      next_dcnt     = dcnt;
      next_bit_cnt  = bit_cnt;
      next_word_cnt = word_cnt;
      next_phase_b  = phase_b;
      next_sh       = sh;
      next_lk_hold  = lk_hold;
      next_lk_tgl   = lk_tgl;
      take          = 1'b0;
      first         = 1'b0;
      word_done     = 1'b0;
      src           = 32'h0000_0000;
      shifted       = 32'h0000_0000;
      result        = 32'h0000_0000;
      bits          = 6'd0;
      lin           = 16'h0000;

      if (lk_ce)
      begin
         case (state)
            S_IDLE:  take = 1'b0;
            S_DELAY:
            begin
               if (dcnt == 2'd1)
               begin
                  take  = 1'b1;
                  first = 1'b1;
               end
               else
                  next_dcnt = dcnt - 2'd1;
            end
            S_DATA:  take = 1'b1;
            default: next_state = S_IDLE;
         endcase

         if (start)
         begin
            next_phase_b  = 1'b0;
            next_word_cnt = 7'd0;
            // data delay, reserved code acts as two
            if (dly == 2'd0)
            begin
               take  = 1'b1;
               first = 1'b1;
            end
            else
            begin
               take       = 1'b0;
               next_state = S_DELAY;
               next_dcnt  = (dly == 2'd3) ? 2'd2 : dly;
            end
         end

         if (take)
         begin
            src     = first ? 32'h0000_0000 : sh;
            shifted = lsb_first ? {24'h000000, RX_DATA, src[7:1]} : {src[30:0], RX_DATA};
            bits    = first ? 6'd1 : bit_cnt + 6'd1;
            next_sh = shifted;
            if (bits == word_bits(cur_wc))
            begin
               word_done = 1'b1;
               result    = shifted;
               if (cur_wc == 3'h0 && srx_cmp_t'(c2[`SRX_CMP_HI:`SRX_CMP_LO]) == CMP_MULAW)
               begin
                  lin    = mu_expand(shifted[7:0]);
                  result = {{16{lin[15]}}, lin};
               end
               else if (cur_wc == 3'h0 && srx_cmp_t'(c2[`SRX_CMP_HI:`SRX_CMP_LO]) == CMP_ALAW)
               begin
                  lin    = a_expand(shifted[7:0]);
                  result = {{16{lin[15]}}, lin};
               end
               next_lk_hold = result;
               next_lk_tgl  = !lk_tgl;
               next_bit_cnt = 6'd0;
               // next word starts clean, no stale upper bits
               next_sh      = 32'h0000_0000;
               // last word of phase ends it
               if ((start ? 7'd0 : word_cnt) == cur_len)
               begin
                  // dual phase continues into phase two
                  if (!eff_b && c2[`SRX_PHASE_BIT])
                  begin
                     next_phase_b  = 1'b1;
                     next_word_cnt = 7'd0;
                     next_state    = S_DATA;
                  end
                  else
                     next_state = S_IDLE;
               end
               else
               begin
                  next_word_cnt = word_cnt + 7'd1;
                  next_state    = S_DATA;
               end
            end
            else
            begin
               next_bit_cnt = bits;
               next_state   = S_DATA;
            end
         end
      end
   end

   // reset and enable follow the link clock through two flops
   always_ff @(posedge lk_clk)
   begin
      lk_rst_m <= SYS_RST;
      lk_rst   <= lk_rst_m;
      lk_ce_m  <= CE;
      lk_ce    <= lk_ce_m;
      lk_cfg_m <= {receive_control_two, receive_control_one};
      lk_cfg   <= lk_cfg_m;
   end

   always_ff @(posedge lk_clk)
   begin
      if (lk_rst)
      begin
         state    <= S_IDLE;
         dcnt     <= 2'd0;
         bit_cnt  <= 6'd0;
         word_cnt <= 7'd0;
         phase_b  <= 1'b0;
         sh       <= 32'h0000_0000;
         lk_hold  <= 32'h0000_0000;
         lk_tgl   <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         dcnt     <= next_dcnt;
         bit_cnt  <= next_bit_cnt;
         word_cnt <= next_word_cnt;
         phase_b  <= next_phase_b;
         sh       <= next_sh;
         lk_hold  <= next_lk_hold;
         lk_tgl   <= next_lk_tgl;
      end
   end

   // checks
   AST_TX_POL: assert property (@(posedge CLK) disable iff (SYS_RST)
      CE |=> TX_EDGE_FALLING == $past(pin_control[`SRX_TXPOL_BIT]))
      else $error("transmit edge select does not follow polarity bit");
   AST_RX_POL: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(lk_clk) |-> RX_SERIAL_CLOCK == pin_control[`SRX_RXPOL_BIT])
      else $error("receive sampling edge wrong for polarity");
   AST_FRAME_END: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      word_done && !start && !phase_b && word_cnt == c1[`SRX_LEN_HI:`SRX_LEN_LO] && !c2[`SRX_PHASE_BIT]
      |=> state == S_IDLE)
      else $error("frame did not end after length plus one words");
   AST_WORD_BITS: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      state == S_DATA |-> bit_cnt < word_bits(phase_b ? c2[`SRX_WL_HI:`SRX_WL_LO] : c1[`SRX_WL_HI:`SRX_WL_LO]))
      else $error("bit count beyond word length");
   AST_DUAL: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      word_done && !eff_b && c2[`SRX_PHASE_BIT] && word_cnt == cur_len && !start
      |=> phase_b && word_cnt == 7'd0 && state == S_DATA)
      else $error("dual phase did not enter second phase");
   AST_WL_B: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      state == S_DATA && phase_b && !RX_FSYNC |-> cur_wc == c2[`SRX_WL_HI:`SRX_WL_LO])
      else $error("second phase not using second word length");
   AST_NO_EXPAND: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      word_done && cur_wc != 3'h0 |=> lk_hold == $past(shifted))
      else $error("non 8-bit word was altered");
   AST_LSB: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      take && lsb_first && !word_done |=> sh[7] == $past(RX_DATA))
      else $error("lsb-first shift wrong");
   AST_ALAW: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      word_done && cur_wc == 3'h0 && c2[`SRX_CMP_HI:`SRX_CMP_LO] == 2'h3
      |=> lk_hold[15:0] == a_expand($past(shifted[7:0])))
      else $error("a-law expansion wrong");
   AST_RESTART: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      state == S_DATA && RX_FSYNC && !c2[`SRX_FIG_BIT] && c2[`SRX_DLY_HI:`SRX_DLY_LO] == 2'd2
      |=> state == S_DELAY ##1 state == S_DELAY ##1 state == S_DATA && bit_cnt == 6'd1)
      else $error("frame sync did not restart with two-bit delay");
   AST_MULAW: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      word_done && cur_wc == 3'h0 && c2[`SRX_CMP_HI:`SRX_CMP_LO] == 2'h2
      |=> lk_hold[15:0] == mu_expand($past(shifted[7:0])))
      else $error("mu-law expansion wrong");
   AST_DELAY1: assert property (@(posedge lk_clk) disable iff (lk_rst || !lk_ce)
      state == S_IDLE && RX_FSYNC && c2[`SRX_DLY_HI:`SRX_DLY_LO] == 2'd1
      |=> state == S_DELAY ##1 state == S_DATA && bit_cnt == 6'd1)
      else $error("one-bit delay not honoured");
   AST_RSVD: assert property (@(posedge CLK) disable iff (SYS_RST)
      (receive_control_one & ~`SRX_CTL1_MASK) == 16'h0000 && (transmit_control_one & ~`SRX_CTL1_MASK) == 16'h0000)
      else $error("reserved control bits not zero");

   COV_DUAL: cover property (@(posedge lk_clk) disable iff (lk_rst) word_done && phase_b && next_state == S_IDLE);
   COV_RESTART: cover property (@(posedge lk_clk) disable iff (lk_rst) state == S_DATA && start);
   COV_ALAW: cover property (@(posedge lk_clk) disable iff (lk_rst)
      word_done && cur_wc == 3'h0 && c2[`SRX_CMP_HI:`SRX_CMP_LO] == 2'h3);
   COV_READ: cover property (@(posedge CLK) disable iff (SYS_RST) rx_full ##1 !rx_full);

endmodule

// ### rtl/srx_defs.svh
`ifndef SRX_DEFS_SVH
`define SRX_DEFS_SVH

// register byte offsets
`define SRX_OFF_PIN      8'h00
`define SRX_OFF_RC1      8'h04
`define SRX_OFF_RC2      8'h08
`define SRX_OFF_TC1      8'h0c
`define SRX_OFF_DATA     8'h10
`define SRX_OFF_STAT     8'h14

// reset values and writable-bit masks
`define SRX_RST_VAL      16'h0000
`define SRX_PIN_MASK     16'h0003
`define SRX_CTL1_MASK    16'h7fe0
`define SRX_CTL2_MASK    16'hffff

// field positions
`define SRX_RXPOL_BIT    0
`define SRX_TXPOL_BIT    1
`define SRX_PHASE_BIT    15
`define SRX_LEN_HI       14
`define SRX_LEN_LO       8
`define SRX_WL_HI        7
`define SRX_WL_LO        5
`define SRX_CMP_HI       4
`define SRX_CMP_LO       3
`define SRX_FIG_BIT      2
`define SRX_DLY_HI       1
`define SRX_DLY_LO       0

// status bits
`define SRX_ST_FULL      0
`define SRX_ST_OVR       1

`endif

// ### rtl/srx_pkg.sv
package srx_pkg;

   typedef enum logic [1:0] {S_IDLE, S_DELAY, S_DATA} srx_state_t;

   typedef enum logic [1:0] {CMP_MSB, CMP_LSB, CMP_MULAW, CMP_ALAW} srx_cmp_t;

endpackage

// ### testbench/srx_codec_model.sv
`timescale 1ns/10ps
module srx_codec_model
(
   // link pins
   output logic      SCLK,
   output logic      FSYNC,
   output logic      SDATA,
   // sampling edge, 1 = rising
   input  wire logic POL
);
   initial
   begin
      SCLK = 1'b0;
      FSYNC = 1'b0;
      SDATA = 1'b0;
   end
   // data moves mid way through the half before the sampling edge, so a wrong-edge sampler sees the old bit
   task automatic slot(input logic fs, input logic d);
      SCLK = ~POL;
      #31.25;
      FSYNC = fs;
      SDATA = d;
      #31.25;
      SCLK = POL;
      #62.5;
   endtask
   // unowned data line keeps changing
   task automatic idle(input int n);
      for (int i = 0; i < n; i++)
         slot(1'b0, ~SDATA);
   endtask
   task automatic frame(input logic [31:0] w, input int n, input int dly, input logic [31:0] fsm);
      for (int i = 0; i < dly; i++)
         slot(i == 0, ~SDATA);
      for (int i = n - 1; i >= 0; i--)
         slot(fsm[i] | (dly == 0 && i == n - 1), w[i]);
   endtask
endmodule

// ### testbench/test_serial_port_receive_frame_config.sv
`timescale 1ns/10ps
`include "srx_defs.svh"
module test_serial_port_receive_frame_config;
   typedef struct packed
   {
      logic [15:0] pc;
      logic [15:0] rc1;
      logic [15:0] rc2;
      logic [31:0] w;
      logic [5:0]  n;
      logic [31:0] exp;
   } srx_row_t;
   localparam srx_row_t ROWS [13] = '{
      '{16'h0, 16'h0000, 16'h0001, 32'ha5, 6'd8, 32'ha5},
      '{16'h1, 16'h0020, 16'h0000, 32'h5c3, 6'd12, 32'h5c3},
      '{16'h2, 16'h0040, 16'h0002, 32'hbeef, 6'd16, 32'hbeef},
      '{16'h3, 16'h0060, 16'h0003, 32'h12345, 6'd20, 32'h12345},
      '{16'h0, 16'h0080, 16'h0001, 32'habcdef, 6'd24, 32'habcdef},
      '{16'h1, 16'h00a0, 16'h0000, 32'hdeadbeef, 6'd32, 32'hdeadbeef},
      '{16'h0, 16'h00c0, 16'h0001, 32'h13579bdf, 6'd32, 32'h13579bdf},
      '{16'h0, 16'h0000, 16'h0009, 32'h0b, 6'd8, 32'hd0},
      '{16'h1, 16'h0000, 16'h0010, 32'h80, 6'd8, 32'h7d7c},
      '{16'h0, 16'h0000, 16'h0011, 32'hff, 6'd8, 32'h0},
      '{16'h2, 16'h0000, 16'h0018, 32'haa, 6'd8, 32'h7e00},
      '{16'h0, 16'h0000, 16'h0019, 32'h55, 6'd8, 32'hfffffff8},
      '{16'h0, 16'h0020, 16'h0018, 32'h0aa, 6'd12, 32'h0aa}};
   localparam logic [15:0] MASKS [4] = '{16'h0003, 16'h7fe0, 16'hffff, 16'h7fe0};
   logic        clk     = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sclk;
   logic        fsync;
   logic        sdata;
   logic        word_valid;
   logic        tx_falling;
   logic        pol     = 1'b0;
   logic        ce      = 1'b1;
   logic [31:0] rdat;
   logic        rerr;
   int          error_cnt = 0;
   int          checked   = 0;
   always #2.5 clk = ~clk;
   srx_rx_config uut (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .RX_SERIAL_CLOCK(sclk), .RX_FSYNC(fsync), .RX_DATA(sdata),
      .RX_WORD_VALID(word_valid), .TX_EDGE_FALLING(tx_falling));
   srx_codec_model model (.SCLK(sclk), .FSYNC(fsync), .SDATA(sdata), .POL(pol));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // only the watchdog ends a wait
      while (pready !== 1'b1)
         @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // link keeps toggling so its reset flops see edges
   task automatic do_reset();
      sys_rst <= 1'b1;
      fork
         repeat (16) @(posedge clk);
         model.idle(4);
      join
      @(posedge clk);
      sys_rst <= 1'b0;
      model.idle(3);
   endtask
   // config crosses on link edges, so idle slots follow
   task automatic cfg(input logic [15:0] pc, input logic [15:0] c1, input logic [15:0] c2);
      apb(1'b1, `SRX_OFF_PIN, {16'h0, pc});
      apb(1'b1, `SRX_OFF_RC1, {16'h0, c1});
      apb(1'b1, `SRX_OFF_RC2, {16'h0, c2});
      pol = pc[0];
      model.idle(4);
   endtask
   task automatic expect_rx(input logic [31:0] st, input logic [31:0] dat);
      model.idle(4);
      check("valid", {31'h0, word_valid}, {31'h0, st[0]});
      apb(1'b0, `SRX_OFF_STAT, 32'h0);
      check("status", rdat, st);
      apb(1'b0, `SRX_OFF_DATA, 32'h0);
      check("data", rdat, dat);
   endtask
   initial
   begin
      #400us;
      error_cnt++;
      end_sim();
   end
   initial
   begin
      do_reset();
      foreach (ROWS[i])
      begin
         cfg(ROWS[i].pc, ROWS[i].rc1, ROWS[i].rc2);
         model.frame(ROWS[i].w, ROWS[i].n, ROWS[i].rc2[1:0] == 2'b11 ? 2 : ROWS[i].rc2[1:0], 32'h0);
         expect_rx(32'h1, ROWS[i].exp);
         check("tx edge", {31'h0, tx_falling}, {31'h0, ROWS[i].pc[1]});
      end
      do_reset();
      check("ready", {31'h0, pready}, 32'h0);
      check("valid", {31'h0, word_valid}, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check("reset value", rdat, 32'h0);
         apb(1'b1, 8'(i * 4), 32'hffffffff);
         apb(1'b0, 8'(i * 4), 32'h0);
         check("writable bits", rdat, {16'h0, MASKS[i]});
         apb(1'b1, 8'(i * 4), 32'h0);
      end
      // enable low holds the answer back
      ce <= 1'b0;
      fork
         apb(1'b1, `SRX_OFF_PIN, 32'h2);
         begin
            repeat (8) @(posedge clk);
            check("stalled ready", {31'h0, pready}, 32'h0);
            ce <= 1'b1;
         end
      join
      repeat (2) @(posedge clk);
      check("tx edge after stall", {31'h0, tx_falling}, 32'h1);
      apb(1'b1, 8'h18, 32'hffffffff);
      check("unmapped err", {31'h0, rerr}, 32'h1);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped data", rdat, 32'h0);
      cfg(16'h0, 16'h0140, 16'h0000);
      model.frame(32'h1234abcd, 32, 0, 32'h0);
      expect_rx(32'h3, 32'habcd);
      cfg(16'h0, 16'h0040, 16'h0000);
      model.frame(32'habcd5a, 24, 0, 32'h0);
      expect_rx(32'h1, 32'habcd);
      cfg(16'h0, 16'h0040, 16'h8000);
      model.frame(32'h12345a, 24, 0, 32'h0);
      expect_rx(32'h3, 32'h5a);
      // later sync restarts the word, then is ignored with the FIG bit set
      cfg(16'h0, 16'h0000, 16'h0000);
      model.frame(32'h3c5, 12, 0, 32'h080);
      expect_rx(32'h1, 32'hc5);
      cfg(16'h0, 16'h0000, 16'h0004);
      model.frame(32'h3c5, 12, 0, 32'h080);
      expect_rx(32'h1, 32'h3c);
      // restart mid-word with a two-bit delay
      cfg(16'h0, 16'h0000, 16'h0002);
      model.frame(32'h3ea5, 14, 2, 32'h200);
      expect_rx(32'h1, 32'ha5);
      end_sim();
   end
endmodule
